// *** hw/tcu_pkg.sv ***
`default_nettype none
package tcu_pkg;
    // Capture unit count and timer choices
    localparam int UNIT_NUM       = 4;
    localparam int TMR_NUM        = 3;
    localparam int CNT_W          = 16;

    // APB map (byte addresses), each unit takes a block of four words
    localparam logic [11:0] UNIT_STRIDE  = 12'h010;
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_CAPSEL   = 12'h004;
    localparam logic [11:0] OFS_VAL_LOW  = 12'h008;
    localparam logic [11:0] OFS_VAL_HIGH = 12'h00C;
    localparam logic [11:0] OFS_TMR_A    = 12'h040;
    localparam logic [11:0] OFS_TMR_B    = 12'h044;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h048;
    localparam logic [11:0] OFS_IRQ_CLR  = 12'h04C;
    localparam logic [11:0] OFS_IRQ_EN   = 12'h050;

    // Control register fields
    localparam int CTRL_EN_BIT    = 7;
    localparam int CTRL_OD_BIT    = 6;
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_MODE_W    = 4;
    localparam int CAPSEL_W       = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Capture edge mode encodings
    localparam logic [3:0] MODE_EDGE_ANY  = 4'h3;
    localparam logic [3:0] MODE_FALL      = 4'h4;
    localparam logic [3:0] MODE_RISE      = 4'h5;
    localparam logic [3:0] MODE_RISE_4TH  = 4'h6;
    localparam logic [3:0] MODE_RISE_16TH = 4'h7;
    localparam logic [3:0] PRESC_4_LAST   = 4'h3;
    localparam logic [3:0] PRESC_16_LAST  = 4'hF;

    typedef struct packed {
        logic       enable;
        logic       open_drain;
        logic [3:0] mode;
        logic [2:0] src_sel;
        logic [1:0] tmr_sel;
    } tcu_cfg_t;
endpackage : tcu_pkg
`default_nettype wire

// *** hw/tcu_sync.sv ***
`default_nettype none
module tcu_sync (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic stage_ff;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage_ff <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage_ff <= async_in;
            sync_out <= stage_ff;
        end
    end
endmodule : tcu_sync
`default_nettype wire

// *** hw/tcu_unit.sv ***
`default_nettype none
module tcu_unit #(
    parameter logic [3:0] MODE_EDGE_ANY  = tcu_pkg::MODE_EDGE_ANY,
    parameter logic [3:0] MODE_FALL      = tcu_pkg::MODE_FALL,
    parameter logic [3:0] MODE_RISE      = tcu_pkg::MODE_RISE,
    parameter logic [3:0] MODE_RISE_4TH  = tcu_pkg::MODE_RISE_4TH,
    parameter logic [3:0] MODE_RISE_16TH = tcu_pkg::MODE_RISE_16TH
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    input  wire tcu_pkg::tcu_cfg_t cfg_in,
    input  wire logic [7:0]       trig_src_in,
    input  wire logic [15:0]      timer_in,
    output var  logic [15:0]      value_out,
    output var  logic             capture_out
);
    // ==========================================================
    // Trigger synchronisation and edge detection
    logic trig_sync;
    logic trig_prev_ff;
    logic rise;
    logic fall;
    logic [3:0] presc_ff;
    logic cap_mode;
    logic hit;

    tcu_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (trig_src_in[cfg_in.src_sel]),
        .sync_out   (trig_sync)
    );

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trig_prev_ff <= 1'b0;
        end else begin
            trig_prev_ff <= trig_sync;
        end
    end

    assign rise = trig_sync & ~trig_prev_ff;
    assign fall = ~trig_sync & trig_prev_ff;
    assign cap_mode = cfg_in.enable && (cfg_in.mode == MODE_EDGE_ANY || cfg_in.mode == MODE_FALL
        || cfg_in.mode == MODE_RISE || cfg_in.mode == MODE_RISE_4TH
        || cfg_in.mode == MODE_RISE_16TH);

    // ==========================================================
    // Event qualification
    always_comb begin
        hit = 1'b0;
        if (cap_mode) begin
            if (cfg_in.mode == MODE_EDGE_ANY) begin
                hit = rise | fall;
            end else if (cfg_in.mode == MODE_FALL) begin
                hit = fall;
            end else if (cfg_in.mode == MODE_RISE) begin
                hit = rise;
            end else if (cfg_in.mode == MODE_RISE_4TH) begin
                hit = rise && presc_ff[1:0] == tcu_pkg::PRESC_4_LAST[1:0];
            end else begin
                hit = rise && presc_ff == tcu_pkg::PRESC_16_LAST;
            end
        end
    end

    // Prescaler survives a mode change within capture, so a switch may fire early
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            presc_ff <= 4'h0;
        end else if (!cap_mode) begin
            presc_ff <= 4'h0;
        end else if (rise) begin
            presc_ff <= presc_ff + 4'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_out   <= 16'h0000;
            capture_out <= 1'b0;
        end else begin
            capture_out <= hit;
            if (hit) begin
                value_out <= timer_in;
            end
        end
    end
endmodule : tcu_unit
`default_nettype wire

// *** hw/tcu_top.sv ***
// Decided for this implementation: register access over APB and the address map.
`default_nettype none
module tcu_top #(
    parameter logic [3:0] MODE_EDGE_ANY  = tcu_pkg::MODE_EDGE_ANY,
    parameter logic [3:0] MODE_FALL      = tcu_pkg::MODE_FALL,
    parameter logic [3:0] MODE_RISE      = tcu_pkg::MODE_RISE,
    parameter logic [3:0] MODE_RISE_4TH  = tcu_pkg::MODE_RISE_4TH,
    parameter logic [3:0] MODE_RISE_16TH = tcu_pkg::MODE_RISE_16TH
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output var  logic [31:0] prdata_out,
    output var  logic        pready_out,
    output var  logic        pslverr_out,
    input  wire logic [3:0]  trig_pin_in,
    input  wire logic [3:0]  comparator_one_output_in,
    input  wire logic [3:0]  comparator_two_output_in,
    input  wire logic [3:0]  pin_change_event_in,
    input  wire logic [3:0]  logic_cell_outputs_in,
    input  wire logic [15:0] odd_timer1_in,
    input  wire logic [15:0] odd_timer3_in,
    input  wire logic [15:0] odd_timer5_in,
    output var  logic [3:0]  open_drain_out,
    output var  logic        irq_out
);
    // ==========================================================
    // Registers
    tcu_pkg::tcu_cfg_t cfg [tcu_pkg::UNIT_NUM];
    logic [7:0]  ctrl_ff     [tcu_pkg::UNIT_NUM];
    logic [2:0]  capsel_ff   [tcu_pkg::UNIT_NUM];
    logic [15:0] value       [tcu_pkg::UNIT_NUM];
    logic [3:0]  cap_evt;
    logic [7:0]  tmr_assign_ff;
    logic [3:0]  irq_stat_ff;
    logic [3:0]  irq_en_ff;
    logic [15:0] odd_timers  [tcu_pkg::TMR_NUM];
    logic        wr_acc;
    logic        rd_acc;
    logic [31:0] nxt_prdata;
    logic        nxt_slverr;

    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    assign odd_timers[0] = odd_timer1_in;
    assign odd_timers[1] = odd_timer3_in;
    assign odd_timers[2] = odd_timer5_in;
    assign wr_acc = psel_in && penable_in && pwrite_in && pready_out;
    assign rd_acc = psel_in && !penable_in && !pwrite_in;

    function automatic logic unit_hit(input logic [11:0] addr, input int u,
                                      input logic [11:0] ofs);
        unit_hit = addr == 12'(u * 16) + ofs;
    endfunction : unit_hit

    // ==========================================================
    // Capture units
    for (genvar u = 0; u < tcu_pkg::UNIT_NUM; u++) begin : g_unit
        logic [1:0] tsel;
        assign tsel = tmr_assign_ff[2*u +: 2];
        assign cfg[u].enable     = ctrl_ff[u][tcu_pkg::CTRL_EN_BIT];
        assign cfg[u].open_drain = ctrl_ff[u][tcu_pkg::CTRL_OD_BIT];
        assign cfg[u].mode       = ctrl_ff[u][tcu_pkg::CTRL_MODE_LSB +: tcu_pkg::CTRL_MODE_W];
        assign cfg[u].src_sel    = capsel_ff[u];
        assign cfg[u].tmr_sel    = tsel;

        tcu_unit #(
            .MODE_EDGE_ANY  (MODE_EDGE_ANY),
            .MODE_FALL      (MODE_FALL),
            .MODE_RISE      (MODE_RISE),
            .MODE_RISE_4TH  (MODE_RISE_4TH),
            .MODE_RISE_16TH (MODE_RISE_16TH)
        ) u_unit (
            .ref_clk_in  (ref_clk_in),
            .rst_b_in    (rst_b_in),
            .cfg_in      (cfg[u]),
            .trig_src_in ({logic_cell_outputs_in, pin_change_event_in[u],
                           comparator_two_output_in[u], comparator_one_output_in[u],
                           trig_pin_in[u]}),
            .timer_in    ((tsel < 2'd3) ? odd_timers[tsel] : odd_timers[0]),
            .value_out   (value[u]),
            .capture_out (cap_evt[u])
        );
    end

    // ==========================================================
    // Register writes
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int u = 0; u < tcu_pkg::UNIT_NUM; u++) begin
                ctrl_ff[u]   <= tcu_pkg::CTRL_RST;
                capsel_ff[u] <= 3'h0;
            end
            tmr_assign_ff <= 8'h00;
            irq_en_ff     <= 4'h0;
        end else if (wr_acc && pstrb_in[0]) begin
            for (int u = 0; u < tcu_pkg::UNIT_NUM; u++) begin
                if (unit_hit(paddr_in, u, tcu_pkg::OFS_CTRL)) begin
                    ctrl_ff[u] <= pwdata_in[7:0];
                end
                if (unit_hit(paddr_in, u, tcu_pkg::OFS_CAPSEL)) begin
                    capsel_ff[u] <= pwdata_in[2:0];
                end
            end
            if (paddr_in == tcu_pkg::OFS_TMR_A) begin
                tmr_assign_ff <= pwdata_in[7:0];
            end
            if (paddr_in == tcu_pkg::OFS_IRQ_EN) begin
                irq_en_ff <= pwdata_in[3:0];
            end
        end
    end

    // Hardware set wins over a same-cycle software clear
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_stat_ff <= 4'h0;
        end else if (wr_acc && pstrb_in[0] && paddr_in == tcu_pkg::OFS_IRQ_CLR) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata_in[3:0]) | cap_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | cap_evt;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_out        <= 1'b0;
            open_drain_out <= 4'h0;
        end else begin
            irq_out <= |(irq_stat_ff & irq_en_ff);
            for (int u = 0; u < tcu_pkg::UNIT_NUM; u++) begin
                open_drain_out[u] <= cfg[u].open_drain;
            end
        end
    end

    // ==========================================================
    // Read path: data latched in setup, answered one cycle later
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b1;
        for (int u = 0; u < tcu_pkg::UNIT_NUM; u++) begin
            if (unit_hit(paddr_in, u, tcu_pkg::OFS_CTRL)) begin
                nxt_prdata = {24'h000000, ctrl_ff[u]};
                nxt_slverr = 1'b0;
            end
            if (unit_hit(paddr_in, u, tcu_pkg::OFS_CAPSEL)) begin
                nxt_prdata = {29'h0, capsel_ff[u]};
                nxt_slverr = 1'b0;
            end
            if (unit_hit(paddr_in, u, tcu_pkg::OFS_VAL_LOW)) begin
                nxt_prdata = {24'h000000, value[u][7:0]};
                nxt_slverr = 1'b0;
            end
            if (unit_hit(paddr_in, u, tcu_pkg::OFS_VAL_HIGH)) begin
                nxt_prdata = {24'h000000, value[u][15:8]};
                nxt_slverr = 1'b0;
            end
        end
        if (paddr_in == tcu_pkg::OFS_TMR_A) begin
            nxt_prdata = {24'h000000, tmr_assign_ff};
            nxt_slverr = 1'b0;
        end
        if (paddr_in == tcu_pkg::OFS_TMR_B || paddr_in == tcu_pkg::OFS_IRQ_CLR) begin
            nxt_slverr = 1'b0;
        end
        if (paddr_in == tcu_pkg::OFS_IRQ_STAT) begin
            nxt_prdata = {28'h0, irq_stat_ff};
            nxt_slverr = 1'b0;
        end
        if (paddr_in == tcu_pkg::OFS_IRQ_EN) begin
            nxt_prdata = {28'h0, irq_en_ff};
            nxt_slverr = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= psel_in && !penable_in;
            pslverr_out <= psel_in && !penable_in && nxt_slverr;
            if (rd_acc) begin
                prdata_out <= nxt_prdata;
            end
        end
    end

    // ==========================================================
    // Checks on the capture path
    a_value_load: assert property (
        $rose(cap_evt[0]) && $past(tmr_assign_ff[1:0]) == 2'd0
        |-> value[0] == $past(odd_timers[0]))
        else $error("capture value wrong");

    a_share_timer: assert property (
        $rose(cap_evt[1]) && $past(tmr_assign_ff[3:2]) == 2'd2
        |-> value[1] == $past(odd_timers[2]))
        else $error("shared timer value wrong");

    a_spare_code: assert property (
        $rose(cap_evt[2]) && $past(tmr_assign_ff[5:4]) == 2'd3
        |-> value[2] == $past(odd_timers[0]))
        else $error("spare timer code not on first timer");

    a_third_timer: assert property (
        $rose(cap_evt[3]) && $past(tmr_assign_ff[7:6]) == 2'd1
        |-> value[3] == $past(odd_timers[1]))
        else $error("second odd timer value wrong");

    a_sel_stable: assert property (
        !cap_evt[1] |-> value[1] == $past(value[1]))
        else $error("value changed idle");

    a_off_no_cap: assert property (
        !cfg[2].enable [*3] |-> !cap_evt[2])
        else $error("capture while off");

    // ==========================================================
    // Checks on flags, interrupt and open-drain outputs
    a_irq_sticky: assert property (
        cap_evt[0] |=> irq_stat_ff[0])
        else $error("capture did not set flag");

    a_flag_hold: assert property (
        irq_stat_ff[1] && !(wr_acc && paddr_in == tcu_pkg::OFS_IRQ_CLR)
        |=> irq_stat_ff[1])
        else $error("flag cleared by hardware");

    a_flag_clear: assert property (
        wr_acc && pstrb_in[0] && paddr_in == tcu_pkg::OFS_IRQ_CLR && pwdata_in[2]
        && !cap_evt[2] |=> !irq_stat_ff[2])
        else $error("flag not cleared by software");

    a_flag_source: assert property (
        !irq_stat_ff[3] && !cap_evt[3] |=> !irq_stat_ff[3])
        else $error("flag set without capture");

    a_irq_level: assert property (
        |(irq_stat_ff & irq_en_ff) |=> irq_out)
        else $error("irq not raised");

    a_irq_quiet: assert property (
        !(|(irq_stat_ff & irq_en_ff)) |=> !irq_out)
        else $error("irq raised without enabled flag");

    a_od_follow: assert property (
        cfg[3].open_drain |=> open_drain_out[3])
        else $error("open drain lag");

    a_od_release: assert property (
        !cfg[3].open_drain |=> !open_drain_out[3])
        else $error("open drain stuck");

    // ==========================================================
    // Checks on the register bus
    a_ready_timing: assert property (
        psel_in && !penable_in |=> pready_out)
        else $error("pready late");

    a_ready_pulse: assert property (
        pready_out |=> !pready_out)
        else $error("pready held too long");

    a_err_flag: assert property (
        psel_in && !penable_in && nxt_slverr |=> pslverr_out)
        else $error("unmapped access not flagged");

    a_err_clean: assert property (
        psel_in && !penable_in && !nxt_slverr |=> !pslverr_out)
        else $error("mapped access flagged");

    a_byte_low: assert property (
        rd_acc && paddr_in == tcu_pkg::OFS_VAL_LOW
        |=> prdata_out == {24'h000000, $past(value[0][7:0])})
        else $error("low byte read wrong");

    a_byte_high: assert property (
        rd_acc && paddr_in == tcu_pkg::OFS_VAL_HIGH + tcu_pkg::UNIT_STRIDE
        |=> prdata_out == {24'h000000, $past(value[1][15:8])})
        else $error("high byte read wrong");

    a_ctrl_write: assert property (
        wr_acc && pstrb_in[0] && paddr_in == tcu_pkg::OFS_CTRL
        |=> ctrl_ff[0] == $past(pwdata_in[7:0]))
        else $error("control write lost");

    // Scenarios worth seeing
    c_capture: cover property (cap_evt[0]);
    c_irq: cover property ($rose(irq_out));
    c_two_caps: cover property (cap_evt[0] ##[1:50] cap_evt[0]);
    c_slverr: cover property (pready_out && pslverr_out);
    c_shared: cover property (cap_evt[1] && tmr_assign_ff[3:2] == 2'd2);
endmodule : tcu_top
`default_nettype wire

// *** test/tcu_src_model.sv ***
`default_nettype none
// ==========================================
// Trigger sources and odd timers at the far side
module tcu_src_model (
    input  wire logic        ref_clk_in,
    output var  logic [3:0]  trig_pin_out,
    output var  logic [3:0]  cmp_one_out,
    output var  logic [3:0]  cmp_two_out,
    output var  logic [3:0]  pin_change_out,
    output var  logic [3:0]  cell_out,
    output var  logic [15:0] tmr1_out,
    output var  logic [15:0] tmr3_out,
    output var  logic [15:0] tmr5_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {trig_pin_out, cmp_one_out, cmp_two_out, pin_change_out, cell_out} = 20'h00000;
        {tmr1_out, tmr3_out, tmr5_out} = 48'h000000000000;
    end
    // Pin is the real wire level, also when software drives it as an output
    task set_src(input int s, input int u, input logic v);
        @(posedge ref_clk_in);
        case (s)
            0:       trig_pin_out[u] <= v;
            1:       cmp_one_out[u] <= v;
            2:       cmp_two_out[u] <= v;
            3:       pin_change_out[u] <= v;
            default: cell_out[s-4] <= v;
        endcase
    endtask : set_src
    // Timers move only on the system clock edge, never asynchronously
    task set_tmr(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge ref_clk_in);
        tmr1_out <= a;
        tmr3_out <= b;
        tmr5_out <= c;
    endtask : set_tmr
endmodule : tcu_src_model
`default_nettype wire

// *** test/tb_timer_capture_unit.sv ***
`default_nettype none
module tb_timer_capture_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [3:0]  pstrb = 4'h0, tp, c1, c2, pc, cl, od;
    logic [15:0] t1, t3, t5, v;
    logic        pready, pslverr, slv, irq;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    localparam logic [7:0] EN = 8'h80;
    always #2 ref_clk_in = ~ref_clk_in;
    tcu_src_model m (.ref_clk_in(ref_clk_in), .trig_pin_out(tp), .cmp_one_out(c1),
        .cmp_two_out(c2), .pin_change_out(pc), .cell_out(cl), .tmr1_out(t1),
        .tmr3_out(t3), .tmr5_out(t5));
    tcu_top dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .trig_pin_in(tp), .comparator_one_output_in(c1), .comparator_two_output_in(c2),
        .pin_change_event_in(pc), .logic_cell_outputs_in(cl), .odd_timer1_in(t1),
        .odd_timer3_in(t3), .odd_timer5_in(t5), .open_drain_out(od), .irq_out(irq));
    // ==========================================
    // Bus and compare helpers
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Request stands until the edge that samples pready high; data is taken at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [11:0] ua(input int u, input logic [11:0] o);
        return o + 12'(u) * tcu_pkg::UNIT_STRIDE;
    endfunction : ua
    task cfg(input int u, input logic [7:0] c);
        apb(1'b1, ua(u, tcu_pkg::OFS_CTRL), {24'h000000, c});
    endtask : cfg
    task ev(input int s, input int u, input logic lv);
        m.set_src(s, u, lv);
        repeat (8) @(posedge ref_clk_in);
    endtask : ev
    task stat(input logic [31:0] exp);
        apb(1'b0, tcu_pkg::OFS_IRQ_STAT, 32'h0);
        chk("irq_stat", rd, exp);
        apb(1'b1, tcu_pkg::OFS_IRQ_CLR, 32'h0000000F);
    endtask : stat
    // Unit stays disabled while the two bytes are read, so the pair cannot tear
    task rdv(input int u);
        apb(1'b0, ua(u, tcu_pkg::OFS_VAL_LOW), 32'h0);
        v[7:0] = rd[7:0];
        apb(1'b0, ua(u, tcu_pkg::OFS_VAL_HIGH), 32'h0);
        v[15:8] = rd[7:0];
    endtask : rdv
    // ==========================================
    // Scenarios
    task t_reset;
        apb(1'b0, ua(2, tcu_pkg::OFS_CTRL), 32'h0);
        chk("ctrl_rst", rd, {24'h0, tcu_pkg::CTRL_RST});
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped_err", {31'h0, slv}, 32'h1);
        chk("unmapped_rd", rd, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task t_sources;
        for (int s = 0; s < 8; s++) begin
            m.set_tmr(16'hA100 + 16'(s), 16'h0000, 16'h0000);
            apb(1'b1, ua(s % 4, tcu_pkg::OFS_CAPSEL), 32'(s));
            cfg(s % 4, EN | tcu_pkg::MODE_RISE);
            ev(s, s % 4, 1'b1);
            cfg(s % 4, 8'h00);
            rdv(s % 4);
            chk("cap_value", {16'h0, v}, {16'h0, 16'hA100 + 16'(s)});
            stat(32'(1 << (s % 4)));
            ev(s, s % 4, 1'b0);
        end
        $display("test sources done");
    endtask : t_sources
    task t_count(input logic [3:0] md, input int n);
        cfg(0, EN | md);
        for (int i = 1; i <= n; i++) begin
            ev(0, 0, 1'b1);
            apb(1'b0, tcu_pkg::OFS_IRQ_STAT, 32'h0);
            chk("rise_count", rd, {31'h0, i == n});
            ev(0, 0, 1'b0);
        end
        stat(32'h1);
        cfg(0, 8'h00);
    endtask : t_count
    task t_edges;
        apb(1'b1, ua(0, tcu_pkg::OFS_CAPSEL), 32'h0);
        cfg(0, EN | tcu_pkg::MODE_FALL);
        ev(0, 0, 1'b1);
        stat(32'h0);
        ev(0, 0, 1'b0);
        stat(32'h1);
        cfg(0, EN | tcu_pkg::MODE_EDGE_ANY);
        ev(0, 0, 1'b1);
        stat(32'h1);
        ev(0, 0, 1'b0);
        stat(32'h1);
        cfg(0, 8'h00);
        t_count(tcu_pkg::MODE_RISE_4TH, 4);
        t_count(tcu_pkg::MODE_RISE_16TH, 16);
        cfg(0, EN | tcu_pkg::MODE_RISE_4TH);
        ev(0, 0, 1'b1);
        ev(0, 0, 1'b0);
        ev(0, 0, 1'b1);
        ev(0, 0, 1'b0);
        cfg(0, 8'h00);
        t_count(tcu_pkg::MODE_RISE_4TH, 4);
        $display("test edges done");
    endtask : t_edges
    task t_share;
        apb(1'b1, tcu_pkg::OFS_TMR_A, 32'h0000007A);
        apb(1'b1, ua(1, tcu_pkg::OFS_CAPSEL), 32'h0);
        apb(1'b1, ua(2, tcu_pkg::OFS_CAPSEL), 32'h0);
        m.set_tmr(16'h1111, 16'h3333, 16'h5A5A);
        for (int u = 0; u < 3; u++) cfg(u, EN | tcu_pkg::MODE_RISE);
        for (int u = 0; u < 3; u++) ev(0, u, 1'b1);
        m.set_tmr(16'h1111, 16'h3333, 16'hC3C3);
        ev(0, 0, 1'b0);
        ev(0, 0, 1'b1);
        for (int u = 0; u < 3; u++) cfg(u, 8'h00);
        rdv(0);
        chk("overwrite", {16'h0, v}, 32'h0000C3C3);
        rdv(1);
        chk("shared_t5", {16'h0, v}, 32'h00005A5A);
        rdv(2);
        chk("sel3_t1", {16'h0, v}, 32'h00001111);
        stat(32'h7);
        for (int u = 0; u < 3; u++) ev(0, u, 1'b0);
        $display("test share done");
    endtask : t_share
    task t_irq;
        apb(1'b1, tcu_pkg::OFS_IRQ_EN, 32'h00000008);
        apb(1'b1, ua(3, tcu_pkg::OFS_CAPSEL), 32'h0);
        cfg(3, EN | 8'h40 | tcu_pkg::MODE_RISE);
        ev(0, 3, 1'b1);
        chk("open_drain", {28'h0, od}, 32'h00000008);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1'b1, tcu_pkg::OFS_IRQ_EN, 32'h0);
        repeat (3) @(negedge ref_clk_in);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        apb(1'b1, tcu_pkg::OFS_IRQ_EN, 32'h00000008);
        repeat (30) @(negedge ref_clk_in);
        chk("irq_sticky", {31'h0, irq}, 32'h1);
        apb(1'b0, tcu_pkg::OFS_IRQ_CLR, 32'h0);
        chk("clr_reads0", rd, 32'h0);
        stat(32'h8);
        repeat (3) @(negedge ref_clk_in);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        cfg(3, 8'h00);
        rdv(3);
        chk("t3_value", {16'h0, v}, 32'h00003333);
        $display("test irq done");
    endtask : t_irq
    // ==========================================
    // Verdict and sequence
    task finish_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_sources();
        t_edges();
        t_share();
        t_irq();
        finish_test();
    end
endmodule : tb_timer_capture_unit
`default_nettype wire
